/* File: verilog/disp_cfg.svh */
// How it works
// - Normal state rotates pair every period, default 5s.
// - Billing values upper line, informative values lower.
// - Upper list: mains energy, impedance, device energy.
// - Normal lower list: nine informative items in order.
// - Charging lower list: eight informative items in order.
// - Charging rotates the same way, default 5s.
// - Charging state shows the charging label.
// - Upper short press steps both lines forward.
// - Lower short press steps both lines back.
// - Normal: upper long press enters self-test.
// - Normal: lower long press enters logbook viewer.
// - Any button action lights backlight for hold time.
// - Charge start in normal enters charging state.
// - Fatal error wins, enters fatal-error state.
// - Otherwise normal state is kept indefinitely.
// - Logbook full: show message, refuse charge start.
// - Identification items unavailable until first charge.
// - Informative registers writable, billing registers refuse writes.
// - Charge stop in charging enters summary state.
// - Long presses ignored in charging state.
`ifndef DISP_CFG_SVH
`define DISP_CFG_SVH

`define CLK_PERIOD_NS 100
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define LONG_PRESS_MS 1000
`define LONG_CYCLES (`LONG_PRESS_MS * 1000000 / `CLK_PERIOD_NS)

`define ROT_SEC_DEF 8'h05
`define BL_SEC_DEF 8'h05

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_BILL0 12'h010
`define OFS_BILL1 12'h014
`define OFS_BILL2 12'h018
`define INFO_PAGE 6'h01

`define CTRL_ROT 7:0
`define CTRL_BL 15:8
`define ST_UPIDX 1:0
`define ST_LOIDX 7:4
`define ST_STATE 13:8
`define ST_FULL 16
`define ST_IDVALID 17
`define ST_REJECT 18
`define ST_BACKLIGHT 19

`define UP_LAST 2'h2
`define LO_LAST_NORM 4'h8
`define LO_LAST_CHG 4'h7

`endif

/* File: verilog/disp_pkg.sv */
`default_nettype none
package disp_pkg;
	typedef enum logic [5:0] {
		ST_NORMAL = 6'h01,
		ST_CHARGING = 6'h02,
		ST_SELFTEST = 6'h04,
		ST_LOGBOOK = 6'h08,
		ST_SUMMARY = 6'h10,
		ST_FATAL = 6'h20
	} disp_state_t;

	typedef enum logic [1:0] {
		UP_MAINS_EN = 2'h0,
		UP_LOSS_IMP = 2'h1,
		UP_TX_DEV_EN = 2'h2
	} upper_item_t;

	typedef enum logic [3:0] {
		LO_VOLT = 4'h0,
		LO_CURR = 4'h1,
		LO_MAINS_PWR = 4'h2,
		LO_DEV_PWR = 4'h3,
		LO_TIME = 4'h4,
		LO_DATE = 4'h5,
		LO_LOSS_EN = 4'h6,
		LO_DEV_EN = 4'h7,
		LO_PUBKEY = 4'h8,
		LO_TX_MAINS_EN = 4'h9,
		LO_TX_LOSS_EN = 4'hA,
		LO_LOSS_PWR = 4'hB,
		LO_TX_DUR = 4'hC
	} lower_item_t;
endpackage
`default_nettype wire

/* File: verilog/disp_ctrl.sv */
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`include "disp_cfg.svh"
`default_nettype none
module disp_ctrl import disp_pkg::*; #(
	parameter int unsigned SEC_CYC = `SEC_CYCLES,
	parameter int unsigned LONG_CYC = `LONG_CYCLES
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic BTN_UPPER_N,
	input wire logic BTN_LOWER_N,
	input wire logic CHARGE_ACTIVE,
	input wire logic FATAL_ERR,
	input wire logic LOGBOOK_FULL,
	input wire logic RETURN_NORMAL,
	input wire logic [31:0] BILL_MAINS_EN,
	input wire logic [31:0] BILL_LOSS_IMP,
	input wire logic [31:0] BILL_TX_DEV_EN,
	output logic [5:0] STATE,
	output logic [1:0] UPPER_ITEM,
	output logic [3:0] LOWER_ITEM,
	output logic [31:0] UPPER_VAL,
	output logic [31:0] LOWER_VAL,
	output logic CHARGING_LABEL,
	output logic LOGBOOK_MSG,
	output logic CHARGE_ALLOWED,
	output logic ID_VALID,
	output logic BACKLIGHT
);
	localparam logic [23:0] SEC_LAST = 24'(SEC_CYC - 1);
	localparam logic [29:0] LONG_LAST = 30'(LONG_CYC - 1);

	logic rst1_r, rst_n;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst1_r <= 1'b1;
			rst_n <= rst1_r;
		end
	end

	// Bits: 0 upper, 1 lower, 2 charge, 3 fatal, 4 full, 5 return.
	logic [5:0] pins, s1_r, s2_r, s3_r;
	assign pins = {RETURN_NORMAL, LOGBOOK_FULL, FATAL_ERR, CHARGE_ACTIVE,
		~BTN_LOWER_N, ~BTN_UPPER_N};
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	logic ev_start, ev_stop, fatal, full, ev_ret;
	assign ev_start = s2_r[2] & ~s3_r[2];
	assign ev_stop = ~s2_r[2] & s3_r[2];
	assign fatal = s2_r[3];
	assign full = s2_r[4];
	assign ev_ret = s2_r[5] & ~s3_r[5];

	// A long press fires while still held so the user sees the change
	// without releasing; the release after it then produces nothing.
	logic [1:0] short_ev, long_ev;
	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_btn
			logic [29:0] hold_r;
			logic long_done_r;
			always_ff @(posedge CLK or negedge rst_n) begin
				if (!rst_n) begin
					hold_r <= '0;
					long_done_r <= 1'b0;
				end else if (!s2_r[b]) begin
					hold_r <= '0;
					long_done_r <= 1'b0;
				end else if (!long_done_r) begin
					if (hold_r == LONG_LAST) begin
						long_done_r <= 1'b1;
					end else begin
						hold_r <= hold_r + 30'h0000_0001;
					end
				end
			end
			assign short_ev[b] = s3_r[b] & ~s2_r[b] & ~long_done_r;
			assign long_ev[b] = s2_r[b] & ~long_done_r & (hold_r == LONG_LAST);
		end
	endgenerate

	logic [23:0] sec_cnt_r;
	logic tick;
	assign tick = (sec_cnt_r == SEC_LAST);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_r <= '0;
		end else if (tick) begin
			sec_cnt_r <= '0;
		end else begin
			sec_cnt_r <= sec_cnt_r + 24'h00_0001;
		end
	end

	disp_state_t st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_NORMAL: begin
				if (fatal) begin
					st_nxt = ST_FATAL;
				end else if (ev_start && !full) begin
					st_nxt = ST_CHARGING;
				end else if (long_ev[0]) begin
					st_nxt = ST_SELFTEST;
				end else if (long_ev[1]) begin
					st_nxt = ST_LOGBOOK;
				end else begin
					st_nxt = ST_NORMAL;
				end
			end
			ST_CHARGING: begin
				if (fatal) begin
					st_nxt = ST_FATAL;
				end else if (ev_stop) begin
					st_nxt = ST_SUMMARY;
				end else begin
					st_nxt = ST_CHARGING;
				end
			end
			ST_SELFTEST, ST_LOGBOOK, ST_SUMMARY: begin
				if (fatal) begin
					st_nxt = ST_FATAL;
				end else if (ev_ret) begin
					st_nxt = ST_NORMAL;
				end
			end
			ST_FATAL: st_nxt = ST_FATAL;
			default: st_nxt = ST_NORMAL;
		endcase
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_NORMAL;
		end else begin
			st_r <= st_nxt;
		end
	end

	logic [31:0] ctrl_r;
	logic [7:0] rot_sec;
	assign rot_sec = ctrl_r[`CTRL_ROT];

	logic rotating, chg, rot_due, step_fwd, step_back;
	logic [7:0] rot_cnt_r;
	logic [1:0] up_idx_r;
	logic [3:0] lo_idx_r, lo_last;
	assign rotating = (st_r == ST_NORMAL) || (st_r == ST_CHARGING);
	assign chg = (st_r == ST_CHARGING);
	assign lo_last = chg ? `LO_LAST_CHG : `LO_LAST_NORM;
	// A period of zero behaves as one second rather than stalling.
	assign rot_due = tick && (rot_cnt_r + 8'h01 >= rot_sec);
	assign step_fwd = rotating && (short_ev[0] || rot_due);
	assign step_back = rotating && short_ev[1] && !short_ev[0];

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rot_cnt_r <= '0;
		end else if (st_nxt != st_r || short_ev != 2'h0 || rot_due) begin
			rot_cnt_r <= '0;
		end else if (tick) begin
			rot_cnt_r <= rot_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			up_idx_r <= '0;
			lo_idx_r <= '0;
		end else if (st_nxt != st_r) begin
			up_idx_r <= '0;
			lo_idx_r <= '0;
		end else if (step_fwd) begin
			up_idx_r <= (up_idx_r == `UP_LAST) ? 2'h0 : up_idx_r + 2'h1;
			lo_idx_r <= (lo_idx_r == lo_last) ? 4'h0 : lo_idx_r + 4'h1;
		end else if (step_back) begin
			up_idx_r <= (up_idx_r == 2'h0) ? `UP_LAST : up_idx_r - 2'h1;
			lo_idx_r <= (lo_idx_r == 4'h0) ? lo_last : lo_idx_r - 4'h1;
		end
	end

	function automatic lower_item_t lower_code(input logic c,
		input logic [3:0] i);
		lower_item_t r;
		r = LO_PUBKEY;
		if (c) begin
			case (i)
				4'h0: r = LO_PUBKEY;
				4'h1: r = LO_TX_MAINS_EN;
				4'h2: r = LO_TX_LOSS_EN;
				4'h3: r = LO_DEV_PWR;
				4'h4: r = LO_LOSS_PWR;
				4'h5: r = LO_MAINS_PWR;
				4'h6: r = LO_TIME;
				4'h7: r = LO_TX_DUR;
				default: r = LO_PUBKEY;
			endcase
		end else begin
			case (i)
				4'h0: r = LO_VOLT;
				4'h1: r = LO_CURR;
				4'h2: r = LO_MAINS_PWR;
				4'h3: r = LO_DEV_PWR;
				4'h4: r = LO_TIME;
				4'h5: r = LO_DATE;
				4'h6: r = LO_LOSS_EN;
				4'h7: r = LO_DEV_EN;
				default: r = LO_PUBKEY;
			endcase
		end
		return r;
	endfunction

	logic [31:0] info_r [16];
	logic [31:0] bill [3];
	assign bill[0] = BILL_MAINS_EN;
	assign bill[1] = BILL_LOSS_IMP;
	assign bill[2] = BILL_TX_DEV_EN;
	lower_item_t lo_code;
	assign lo_code = lower_code(chg, lo_idx_r);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			UPPER_ITEM <= '0;
			LOWER_ITEM <= '0;
			UPPER_VAL <= '0;
			LOWER_VAL <= '0;
		end else begin
			UPPER_ITEM <= up_idx_r;
			LOWER_ITEM <= lo_code;
			UPPER_VAL <= (up_idx_r == `UP_LAST) ? bill[2] : bill[up_idx_r];
			LOWER_VAL <= info_r[lo_code];
		end
	end

	logic id_r;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			STATE <= ST_NORMAL;
			CHARGING_LABEL <= 1'b0;
			LOGBOOK_MSG <= 1'b0;
			CHARGE_ALLOWED <= 1'b0;
			id_r <= 1'b0;
			ID_VALID <= 1'b0;
		end else begin
			STATE <= st_nxt;
			CHARGING_LABEL <= (st_nxt == ST_CHARGING);
			LOGBOOK_MSG <= full;
			CHARGE_ALLOWED <= !full && !fatal;
			if (st_nxt == ST_CHARGING) begin
				id_r <= 1'b1;
			end
			ID_VALID <= id_r || (st_nxt == ST_CHARGING);
		end
	end

	logic [7:0] bl_cnt_r;
	logic btn_any;
	assign btn_any = (short_ev != 2'h0) || (long_ev != 2'h0);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			bl_cnt_r <= '0;
			BACKLIGHT <= 1'b0;
		end else if (btn_any) begin
			bl_cnt_r <= ctrl_r[`CTRL_BL];
			BACKLIGHT <= (ctrl_r[`CTRL_BL] != 8'h00);
		end else if (tick && bl_cnt_r != 8'h00) begin
			bl_cnt_r <= bl_cnt_r - 8'h01;
			BACKLIGHT <= (bl_cnt_r != 8'h01);
		end
	end

	// Zero-wait slave: read data is registered in the address phase, so a
	// read issued right behind a write to the same word sees the old value.
	logic addr_ok, wr_pend_r, reject_r, rej_set, rej_clr;
	logic [11:0] wr_addr_r, ra;
	logic [31:0] status;
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign ra = HADDR[11:0];
	assign status = {12'h000, BACKLIGHT, reject_r, ID_VALID, full, 2'h0,
		st_r, lo_idx_r, 2'h0, up_idx_r};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			wr_pend_r <= addr_ok && HWRITE;
			wr_addr_r <= ra;
			HRDATA <= 32'h0000_0000;
			if (addr_ok && !HWRITE) begin
				if (ra == `OFS_CTRL) begin
					HRDATA <= ctrl_r;
				end else if (ra == `OFS_STATUS) begin
					HRDATA <= status;
				end else if (ra == `OFS_BILL0) begin
					HRDATA <= bill[0];
				end else if (ra == `OFS_BILL1) begin
					HRDATA <= bill[1];
				end else if (ra == `OFS_BILL2) begin
					HRDATA <= bill[2];
				end else if (ra[11:6] == `INFO_PAGE) begin
					HRDATA <= info_r[ra[5:2]];
				end
			end
		end
	end

	assign rej_set = wr_pend_r && (wr_addr_r == `OFS_BILL0 ||
		wr_addr_r == `OFS_BILL1 || wr_addr_r == `OFS_BILL2);
	assign rej_clr = wr_pend_r && (wr_addr_r == `OFS_STATUS) &&
		HWDATA[`ST_REJECT];
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= {16'h0000, `BL_SEC_DEF, `ROT_SEC_DEF};
			reject_r <= 1'b0;
		end else begin
			if (wr_pend_r && wr_addr_r == `OFS_CTRL) begin
				ctrl_r <= {16'h0000, HWDATA[15:0]};
			end
			if (rej_set) begin
				reject_r <= 1'b1;
			end else if (rej_clr) begin
				reject_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				info_r[i] <= 32'h0000_0000;
			end
		end else if (wr_pend_r && wr_addr_r[11:6] == `INFO_PAGE) begin
			info_r[wr_addr_r[5:2]] <= HWDATA;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	sequence s_quiet_normal;
		st_r == ST_NORMAL && st_nxt == ST_NORMAL && short_ev == 2'h0;
	endsequence
	sequence s_enter_chg;
		st_r == ST_NORMAL && ev_start && !full && !fatal;
	endsequence

	rotate_normal_a: assert property (s_quiet_normal ##0 rot_due |=>
		up_idx_r == (($past(up_idx_r) == `UP_LAST) ? 2'h0 :
		$past(up_idx_r) + 2'h1))
		else $error("normal rotation did not advance");
	rotate_chg_a: assert property (chg && st_nxt == ST_CHARGING &&
		rot_due && short_ev == 2'h0 |=> lo_idx_r == (($past(lo_idx_r) ==
		`LO_LAST_CHG) ? 4'h0 : $past(lo_idx_r) + 4'h1))
		else $error("charging rotation did not advance");
	upper_range_a: assert property (up_idx_r <= `UP_LAST)
		else $error("upper index out of list");
	lower_range_a: assert property (chg |-> lo_idx_r <= `LO_LAST_CHG)
		else $error("charging lower index out of list");
	step_back_a: assert property (st_r == ST_NORMAL &&
		st_nxt == ST_NORMAL && short_ev == 2'h2 && !rot_due |=>
		up_idx_r == (($past(up_idx_r) == 2'h0) ? `UP_LAST :
		$past(up_idx_r) - 2'h1))
		else $error("lower short press did not step back");
	chg_entry_a: assert property (s_enter_chg |=> st_r == ST_CHARGING
		##0 CHARGING_LABEL && ID_VALID)
		else $error("charge start not taken");
	fatal_prio_a: assert property ((st_r == ST_NORMAL || chg) && fatal
		|=> st_r == ST_FATAL [*2])
		else $error("fatal error not taken first");
	full_refuse_a: assert property (st_r == ST_NORMAL && full |=>
		st_r != ST_CHARGING && LOGBOOK_MSG && !CHARGE_ALLOWED)
		else $error("logbook full did not refuse charge");
	long_self_a: assert property (st_r == ST_NORMAL && !fatal &&
		!ev_start && long_ev[0] |=> st_r == ST_SELFTEST)
		else $error("upper long press did not enter self-test");
	long_log_a: assert property (st_r == ST_NORMAL && !fatal && !ev_start
		&& !long_ev[0] && long_ev[1] |=> st_r == ST_LOGBOOK)
		else $error("lower long press did not enter logbook");
	chg_long_a: assert property (chg && !fatal && !ev_stop &&
		long_ev != 2'h0 |=> st_r == ST_CHARGING)
		else $error("long press changed charging state");
	chg_stop_a: assert property (chg && !fatal && ev_stop |=>
		st_r == ST_SUMMARY)
		else $error("charge stop did not enter summary");
	backlight_a: assert property (btn_any && ctrl_r[`CTRL_BL] != 8'h00
		|=> BACKLIGHT)
		else $error("button action did not light backlight");
	reject_a: assert property (rej_set |=> reject_r &&
		ctrl_r == $past(ctrl_r))
		else $error("billing write not rejected");
	one_event_a: assert property (long_ev[0] |=>
		(short_ev[0] == 1'b0 && long_ev[0] == 1'b0) [*8])
		else $error("second event from one press");
endmodule // disp_ctrl
`default_nettype wire

/* File: bench/btn_panel.sv */
`default_nettype none
module btn_panel (
	input wire logic clk,
	output logic btn_upper_n,
	output logic btn_lower_n,
	input wire logic [1:0] upper_item,
	input wire logic [3:0] lower_item
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] shown_pair_r = 6'h00;
	int refreshes = 0;

	// Buttons sit on pull-ups, so a released pin reads high.
	initial begin
		btn_upper_n = 1'b1;
		btn_lower_n = 1'b1;
	end

	// The panel redraws only when the pair of shown items changes.
	always @(posedge clk) begin
		if ({upper_item, lower_item} !== shown_pair_r) begin
			shown_pair_r <= {upper_item, lower_item};
			refreshes <= refreshes + 1;
		end
	end

	task automatic press(input logic upper, input int cyc);
		@(posedge clk);
		if (upper) begin
			btn_upper_n <= 1'b0;
		end else begin
			btn_lower_n <= 1'b0;
		end
		repeat (cyc) @(posedge clk);
		btn_upper_n <= 1'b1;
		btn_lower_n <= 1'b1;
	endtask
endmodule // btn_panel
`default_nettype wire

/* File: bench/tb.sv */
`include "disp_cfg.svh"
`default_nettype none
module tb import disp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic CHARGE_ACTIVE = 1'b0;
	logic FATAL_ERR = 1'b0;
	logic LOGBOOK_FULL = 1'b0;
	logic RETURN_NORMAL = 1'b0;
	logic [31:0] bill [3];
	logic HREADYOUT, HRESP, BTN_UPPER_N, BTN_LOWER_N;
	logic [31:0] HRDATA, UPPER_VAL, LOWER_VAL;
	logic [5:0] STATE;
	logic [1:0] UPPER_ITEM;
	logic [3:0] LOWER_ITEM;
	logic CHARGING_LABEL, LOGBOOK_MSG, CHARGE_ALLOWED, ID_VALID, BACKLIGHT;
	int failures = 0;
	int comparisons = 0;
	int up = 0;
	int lo = 0;
	bit chg = 1'b0;
	logic [31:0] info;
	logic [31:0] r;
	lower_item_t chg_lo [8] = '{LO_PUBKEY, LO_TX_MAINS_EN, LO_TX_LOSS_EN,
		LO_DEV_PWR, LO_LOSS_PWR, LO_MAINS_PWR, LO_TIME, LO_TX_DUR};

	always #50 CLK = ~CLK;

	disp_ctrl #(.SEC_CYC(20), .LONG_CYC(8)) u_dut (.CLK, .ARST_N, .HSEL,
		.HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT),
		.HREADYOUT, .HRDATA, .HRESP, .BTN_UPPER_N, .BTN_LOWER_N,
		.CHARGE_ACTIVE, .FATAL_ERR, .LOGBOOK_FULL, .RETURN_NORMAL,
		.BILL_MAINS_EN(bill[0]), .BILL_LOSS_IMP(bill[1]),
		.BILL_TX_DEV_EN(bill[2]), .STATE, .UPPER_ITEM, .LOWER_ITEM,
		.UPPER_VAL, .LOWER_VAL, .CHARGING_LABEL, .LOGBOOK_MSG,
		.CHARGE_ALLOWED, .ID_VALID, .BACKLIGHT);

	btn_panel u_pan (.clk(CLK), .btn_upper_n(BTN_UPPER_N),
		.btn_lower_n(BTN_LOWER_N), .upper_item(UPPER_ITEM),
		.lower_item(LOWER_ITEM));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic ahb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= {20'h0_0000, a};
		HWRITE <= wr;
		HTRANS <= 2'h2;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		chk("okay", 32'(HRESP), 0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [11:0] a);
		ahb(1'b0, a, 32'h0000_0000, r);
	endtask

	// Model step: both lines move together and wrap within their lists.
	task automatic press(input logic upper, input int cyc, input int d);
		int n;
		n = chg ? 8 : 9;
		u_pan.press(upper, cyc);
		up = (up + d + 3) % 3;
		lo = (lo + d + n) % n;
		repeat (8) @(posedge CLK);
	endtask

	task automatic chk_pair();
		chk("upper item", 32'(UPPER_ITEM), 32'(up));
		chk("upper val", UPPER_VAL, bill[up]);
		chk("lower item", 32'(LOWER_ITEM),
			chg ? 32'(chg_lo[lo]) : 32'(lo));
	endtask

	// Pin 0 charge, 1 fatal, 2 logbook full, 3 return to normal.
	task automatic status_in(input int pin, input logic v);
		@(posedge CLK);
		case (pin)
			0: CHARGE_ACTIVE <= v;
			1: FATAL_ERR <= v;
			2: LOGBOOK_FULL <= v;
			default: RETURN_NORMAL <= v;
		endcase
		repeat (6) @(posedge CLK);
	endtask

	task automatic back_normal();
		status_in(3, 1'b1);
		RETURN_NORMAL <= 1'b0;
		up = 0;
		lo = 0;
		chg = 1'b0;
	endtask

	initial begin
		repeat (5000) @(posedge CLK);
		failures++;
		final_report();
	end

	initial begin
		void'($urandom(32'h857776ca));
		foreach (bill[i]) bill[i] = $urandom;
		info = $urandom;
		repeat (5) @(posedge CLK);
		ARST_N <= 1'b1;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		chk("state", 32'(STATE), 32'(ST_NORMAL));
		chk("id valid", 32'(ID_VALID), 0);
		rd(`OFS_CTRL);
		chk("ctrl", r, 32'h0000_0505);
		rd(`OFS_STATUS);
		chk("status", r, 32'h0000_0100);
		wr(`OFS_BILL1, ~bill[1]);
		rd(`OFS_STATUS);
		chk("reject", 32'(r[`ST_REJECT]), 1);
		rd(`OFS_BILL1);
		chk("bill", r, bill[1]);
		wr(`OFS_STATUS, 32'h0004_0000);
		rd(`OFS_STATUS);
		chk("reject clr", 32'(r[`ST_REJECT]), 0);
		wr(12'h044, info);
		rd(12'h044);
		chk("info", r, info);
		rd(12'h800);
		chk("unmapped", r, 0);
		// Long rotation keeps the pair still while stepping by hand.
		wr(`OFS_CTRL, 32'h0000_02C8);
		press(1'b1, 3, 1);
		chk_pair();
		chk("lower val", LOWER_VAL, info);
		chk("light", 32'(BACKLIGHT), 1);
		repeat (37) @(posedge CLK);
		chk("light off", 32'(BACKLIGHT), 0);
		repeat (2) begin
			press(1'b0, 3, -1);
			chk_pair();
		end
		repeat (9) begin
			press(1'b1, 3, 1);
			chk_pair();
		end
		press(1'b1, 15, 0);
		chk("state", 32'(STATE), 32'(ST_SELFTEST));
		wr(`OFS_CTRL, 32'h0000_0202);
		back_normal();
		repeat (44) @(posedge CLK);
		up = 1;
		lo = 1;
		chk_pair();
		chk("state", 32'(STATE), 32'(ST_NORMAL));
		press(1'b0, 15, 0);
		chk("state", 32'(STATE), 32'(ST_LOGBOOK));
		wr(`OFS_CTRL, 32'h0000_02C8);
		back_normal();
		status_in(0, 1'b1);
		chg = 1'b1;
		chk("state", 32'(STATE), 32'(ST_CHARGING));
		chk("label", 32'(CHARGING_LABEL), 1);
		chk("id valid", 32'(ID_VALID), 1);
		chk_pair();
		repeat (8) begin
			press(1'b0, 3, -1);
			chk_pair();
		end
		press(1'b1, 15, 0);
		press(1'b0, 15, 0);
		chk("state", 32'(STATE), 32'(ST_CHARGING));
		chk_pair();
		status_in(0, 1'b0);
		chk("state", 32'(STATE), 32'(ST_SUMMARY));
		back_normal();
		status_in(2, 1'b1);
		chk("msg", 32'(LOGBOOK_MSG), 1);
		chk("allowed", 32'(CHARGE_ALLOWED), 0);
		status_in(0, 1'b1);
		chk("state", 32'(STATE), 32'(ST_NORMAL));
		status_in(1, 1'b1);
		chk("state", 32'(STATE), 32'(ST_FATAL));
		// A second reset must hide the identification items again.
		@(posedge CLK);
		ARST_N <= 1'b0;
		CHARGE_ACTIVE <= 1'b0;
		FATAL_ERR <= 1'b0;
		LOGBOOK_FULL <= 1'b0;
		repeat (3) @(posedge CLK);
		ARST_N <= 1'b1;
		repeat (6) @(posedge CLK);
		chk("state", 32'(STATE), 32'(ST_NORMAL));
		chk("id valid", 32'(ID_VALID), 0);
		chk("allowed", 32'(CHARGE_ALLOWED), 1);
		chk("panel redraw", 32'(u_pan.refreshes > 0), 1);
		final_report();
	end
endmodule // tb
`default_nettype wire
